// ===== verilog/csrsw_regs.sv
// Compare-swap control, ROM header and bus name registers with host port
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "csrsw_map.svh"
module csrsw_regs
    import csrsw_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Host register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Remote quadlet reads
    input  wire logic        remote_rd,
    input  wire logic [1:0]  remote_which,
    output logic      [31:0] remote_rdata,
    output logic             remote_valid,
    // Serial ROM loader
    input  wire logic        serial_rom_present,
    input  wire logic        serial_rom_valid,
    input  wire logic [15:0] serial_rom_check,
    // Status
    output logic             swap_busy,
    output logic             irq
);
    csrsw_bus_req_t    bus;
    csrsw_remote_req_t rem;
    csrsw_state_t      state_reg;
    csrsw_res_t        sel_reg;
    logic              done_reg;
    logic       [31:0] expected_reg;
    logic       [31:0] new_reg;
    logic       [31:0] header_reg;
    logic       [31:0] res_value [4];
    logic       [3:0]  res_go;
    logic              load_pulse;
    logic       [15:0] load_value;
    logic       [1:0]  irq_status_reg;
    logic       [1:0]  irq_mask_reg;
    logic       [1:0]  irq_event;
    logic              swap_finish;
    logic       [31:0] rd_next;

    assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
    assign rem = '{valid: remote_rd, which: remote_which};

    // Operand registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            expected_reg <= 32'h00000000;
            new_reg      <= 32'h00000000;
        end else if (bus.wr && bus.addr == `CSRSW_OFF_EXPECTED) begin
            expected_reg <= bus.wdata;
        end else if (bus.wr && bus.addr == `CSRSW_OFF_NEW) begin
            new_reg <= bus.wdata;
        end
    end

    // Selector latches with each control write
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sel_reg <= CSRSW_RES_MANAGER;
        end else if (bus.wr && bus.addr == `CSRSW_OFF_CONTROL) begin
            sel_reg <= csrsw_res_t'(bus.wdata[`CSRSW_SEL_MSB:0]);
        end
    end

    // Swap sequencer: write starts, compare/store takes one cycle
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_reg <= CSRSW_IDLE;
        end else begin
            unique case (state_reg)
                CSRSW_IDLE: begin
                    if (bus.wr && bus.addr == `CSRSW_OFF_CONTROL) begin
                        state_reg <= CSRSW_COMPARE;
                    end
                end
                CSRSW_COMPARE: begin
                    // A second control write here restarts the swap
                    if (!(bus.wr && bus.addr == `CSRSW_OFF_CONTROL)) begin
                        state_reg <= CSRSW_IDLE;
                    end
                end
            endcase
        end
    end

    assign swap_finish = (state_reg == CSRSW_COMPARE) && !(bus.wr && bus.addr == `CSRSW_OFF_CONTROL);

    // Done flag resets to one; finish in the same cycle as a write cannot occur
    always_ff @(posedge clock) begin
        if (!rstn) begin
            done_reg <= 1'b1;
        end else if (bus.wr && bus.addr == `CSRSW_OFF_CONTROL) begin
            done_reg <= 1'b0;
        end else if (swap_finish) begin
            done_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            swap_busy <= 1'b0;
        end else begin
            swap_busy <= (bus.wr && bus.addr == `CSRSW_OFF_CONTROL) || (state_reg == CSRSW_COMPARE && !swap_finish);
        end
    end

    // Resource words, one swapped per operation
    always_comb begin
        res_go = 4'h0;
        res_go[sel_reg] = swap_finish;
    end

    csrsw_resource #(.RESET_VALUE(`CSRSW_RES_MGR_RESET)) u_res_mgr (
        .clock               (clock),
        .rstn                (rstn),
        .swap_go             (res_go[0]),
        .swap_expected_value (expected_reg),
        .swap_new_value      (new_reg),
        .value_reg           (res_value[0])
    );
    csrsw_resource #(.RESET_VALUE(`CSRSW_RES_BW_RESET)) u_res_bw (
        .clock               (clock),
        .rstn                (rstn),
        .swap_go             (res_go[1]),
        .swap_expected_value (expected_reg),
        .swap_new_value      (new_reg),
        .value_reg           (res_value[1])
    );
    csrsw_resource #(.RESET_VALUE(`CSRSW_RES_CH_RESET)) u_res_hi (
        .clock               (clock),
        .rstn                (rstn),
        .swap_go             (res_go[2]),
        .swap_expected_value (expected_reg),
        .swap_new_value      (new_reg),
        .value_reg           (res_value[2])
    );
    csrsw_resource #(.RESET_VALUE(`CSRSW_RES_CH_RESET)) u_res_lo (
        .clock               (clock),
        .rstn                (rstn),
        .swap_go             (res_go[3]),
        .swap_expected_value (expected_reg),
        .swap_new_value      (new_reg),
        .value_reg           (res_value[3])
    );

    csrsw_check_loader u_loader (
        .clock              (clock),
        .rstn               (rstn),
        .serial_rom_present (serial_rom_present),
        .serial_rom_valid   (serial_rom_valid),
        .serial_rom_check   (serial_rom_check),
        .load_reg           (load_pulse),
        .check_reg          (load_value)
    );

    // Header; serial ROM load wins over a host write of the check field
    always_ff @(posedge clock) begin
        if (!rstn) begin
            header_reg <= `CSRSW_HEADER_RESET;
        end else begin
            if (bus.wr && bus.addr == `CSRSW_OFF_HEADER) begin
                header_reg <= bus.wdata;
            end
            if (load_pulse) begin
                header_reg[`CSRSW_CHECK_MSB:0] <= load_value;
            end
        end
    end

    // Interrupts: bit0 swap done, bit1 check value loaded; set beats clear
    assign irq_event = {load_pulse, swap_finish};

    always_ff @(posedge clock) begin
        if (!rstn) begin
            irq_status_reg <= 2'h0;
        end else if (bus.wr && bus.addr == `CSRSW_OFF_IRQ_STATUS) begin
            irq_status_reg <= (irq_status_reg & ~bus.wdata[1:0]) | irq_event;
        end else begin
            irq_status_reg <= irq_status_reg | irq_event;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            irq_mask_reg <= 2'h0;
        end else if (bus.wr && bus.addr == `CSRSW_OFF_IRQ_MASK) begin
            irq_mask_reg <= bus.wdata[1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // Host read mux; unmapped offsets read zero
    always_comb begin
        rd_next = 32'h00000000;
        unique case (bus.addr)
            `CSRSW_OFF_NEW:        rd_next = new_reg;
            `CSRSW_OFF_EXPECTED:   rd_next = expected_reg;
            `CSRSW_OFF_CONTROL:    rd_next = {done_reg, 29'h00000000, sel_reg};
            `CSRSW_OFF_HEADER:     rd_next = header_reg;
            `CSRSW_OFF_BUSNAME:    rd_next = `CSRSW_BUS_NAME;
            `CSRSW_OFF_IRQ_STATUS: rd_next = {30'h00000000, irq_status_reg};
            `CSRSW_OFF_IRQ_MASK:   rd_next = {30'h00000000, irq_mask_reg};
            8'h50:                 rd_next = res_value[0];
            8'h54:                 rd_next = res_value[1];
            8'h58:                 rd_next = res_value[2];
            8'h5C:                 rd_next = res_value[3];
            default:               rd_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            reg_rdata <= 32'h00000000;
        end else if (bus.rd) begin
            reg_rdata <= rd_next;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    // Remote quadlet reads
    always_ff @(posedge clock) begin
        if (!rstn) begin
            remote_rdata <= 32'h00000000;
            remote_valid <= 1'b0;
        end else begin
            remote_valid <= rem.valid;
            if (rem.valid && rem.which == `CSRSW_REMOTE_ROM0) begin
                remote_rdata <= header_reg;
            end else if (rem.valid && rem.which == `CSRSW_REMOTE_INFO0) begin
                remote_rdata <= `CSRSW_BUS_NAME;
            end else begin
                remote_rdata <= 32'h00000000;
            end
        end
    end
endmodule

// ===== verilog/csrsw_map.svh
// Register offsets, field positions and reset values of the swap and ROM header registers
// How it works
// - Done flag in control bit 31 sets when a compare-swap finishes.
// - Any write to the control register clears the done flag.
// - Selector bits 1:0 pick manager id, bandwidth, channels high, channels low.
// - Control bits 30:2 always read as zero.
// - Compare expected operand with resource; on match store new operand there.
// - An attached serial ROM loads the 16-bit check value field.
// - Remote reads of the first ROM quadlet return the header register.
// - Bus name register at 1Ch is read-only, fixed ASCII 1394.
// - Bus name register answers remote reads of bus info block quadlet zero.
`ifndef CSRSW_MAP_SVH
`define CSRSW_MAP_SVH
`define CSRSW_OFF_EXPECTED   8'h10
`define CSRSW_OFF_NEW        8'h0C
`define CSRSW_OFF_CONTROL    8'h14
`define CSRSW_OFF_HEADER     8'h18
`define CSRSW_OFF_BUSNAME    8'h1C
`define CSRSW_OFF_IRQ_STATUS 8'h40
`define CSRSW_OFF_IRQ_MASK   8'h44
`define CSRSW_OFF_RES_BASE   8'h50
`define CSRSW_DONE_BIT       31
`define CSRSW_SEL_MSB        1
`define CSRSW_CHECK_MSB      15
`define CSRSW_BUS_NAME       32'h31333934
`define CSRSW_HEADER_RESET   32'h00000000
`define CSRSW_RES_MGR_RESET  32'h0000003F
`define CSRSW_RES_BW_RESET   32'h00001333
`define CSRSW_RES_CH_RESET   32'hFFFFFFFF
`define CSRSW_REMOTE_ROM0    2'h0
`define CSRSW_REMOTE_INFO0   2'h1
`endif

// ===== verilog/csrsw_pkg.sv
// Types shared by the swap and ROM header register block
package csrsw_pkg;
    typedef enum logic [1:0] {
        CSRSW_RES_MANAGER,
        CSRSW_RES_BANDWIDTH,
        CSRSW_RES_CHAN_HI,
        CSRSW_RES_CHAN_LO
    } csrsw_res_t;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } csrsw_bus_req_t;
    typedef struct packed {
        logic        valid;
        logic [1:0]  which;
    } csrsw_remote_req_t;
    typedef enum {
        CSRSW_IDLE,
        CSRSW_COMPARE
    } csrsw_state_t;
endpackage

// ===== verilog/csrsw_resource.sv
// One bus-management resource word updated by compare-swap
`timescale 1ns/1ps
`include "csrsw_map.svh"
module csrsw_resource
    import csrsw_pkg::*;
#(
    parameter logic [31:0] RESET_VALUE = 32'h00000000
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Swap request
    input  wire logic        swap_go,
    input  wire logic [31:0] swap_expected_value,
    input  wire logic [31:0] swap_new_value,
    // Current value
    output logic      [31:0] value_reg
);
    always_ff @(posedge clock) begin
        if (!rstn) begin
            value_reg <= RESET_VALUE;
        end else if (swap_go && value_reg == swap_expected_value) begin
            value_reg <= swap_new_value;
        end
    end
endmodule

// ===== verilog/csrsw_check_loader.sv
// Takes the ROM check value from an attached serial ROM loader
`timescale 1ns/1ps
`include "csrsw_map.svh"
module csrsw_check_loader
    import csrsw_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Serial ROM side
    input  wire logic        serial_rom_present,
    input  wire logic        serial_rom_valid,
    input  wire logic [15:0] serial_rom_check,
    // Load strobe and value
    output logic             load_reg,
    output logic      [15:0] check_reg
);
    always_ff @(posedge clock) begin
        if (!rstn) begin
            load_reg  <= 1'b0;
            check_reg <= 16'h0000;
        end else begin
            load_reg <= serial_rom_present && serial_rom_valid;
            if (serial_rom_present && serial_rom_valid) begin
                check_reg <= serial_rom_check;
            end
        end
    end
endmodule

// ===== test/csrsw_regs_checker.sv
// Assertions on the swap control, ROM header and bus name ports
`timescale 1ns/1ps
module csrsw_regs_checker
    import csrsw_pkg::*;
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        rstn,
    // Host port
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Remote reads
    input wire logic        remote_rd,
    input wire logic [1:0]  remote_which,
    input wire logic [31:0] remote_rdata,
    input wire logic        remote_valid,
    // Serial ROM and status
    input wire logic        serial_rom_present,
    input wire logic        serial_rom_valid,
    input wire logic [15:0] serial_rom_check,
    input wire logic        swap_busy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_cw; reg_wr && reg_addr == 8'h14; endsequence
    sequence s_cr; reg_rd && reg_addr == 8'h14; endsequence
    property p_busy; s_cw ##1 !(reg_wr && reg_addr == 8'h14) |-> swap_busy ##1 !swap_busy; endproperty
    a_busy: assert property (p_busy) else $error("busy pulse wrong");
    property p_clr; s_cw ##1 s_cr |=> !reg_rdata[31]; endproperty
    a_clr: assert property (p_clr) else $error("done not cleared");
    property p_done; s_cw ##1 (!reg_wr)[*2] ##1 s_cr |=> reg_rdata[31]; endproperty
    a_done: assert property (p_done) else $error("done not set");
    property p_rsvd; s_cr |=> reg_rdata[30:2] == 29'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_name; reg_rd && reg_addr == 8'h1C |=> reg_rdata == 32'h31333934; endproperty
    a_name: assert property (p_name) else $error("bus name wrong");
    property p_rname; remote_rd && remote_which == 2'h1 |=> remote_valid && remote_rdata == 32'h31333934; endproperty
    a_rname: assert property (p_rname) else $error("remote bus name wrong");
    property p_rhdr;
        remote_rd && remote_which == 2'h0 && reg_rd && reg_addr == 8'h18 |=> remote_valid && remote_rdata == reg_rdata;
    endproperty
    a_rhdr: assert property (p_rhdr) else $error("remote header wrong");
    property p_rom;
        serial_rom_present && serial_rom_valid ##1 (!serial_rom_valid && !reg_wr)[*2] ##1 (reg_rd && reg_addr == 8'h18)
        |=> reg_rdata[15:0] == $past(serial_rom_check, 4);
    endproperty
    a_rom: assert property (p_rom) else $error("check value not loaded");
endmodule

bind csrsw_regs csrsw_regs_checker u_chk (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .remote_rd(remote_rd), .remote_which(remote_which),
    .remote_rdata(remote_rdata), .remote_valid(remote_valid), .serial_rom_present(serial_rom_present),
    .serial_rom_valid(serial_rom_valid), .serial_rom_check(serial_rom_check), .swap_busy(swap_busy));

// ===== test/tb_csrsw_regs.sv
// Self-checking bench for the swap control and ROM header registers
`timescale 1ns/1ps
module tb_csrsw_regs;
    import csrsw_pkg::*;
    logic        clock, rstn, reg_wr, reg_rd, remote_rd, remote_valid, swap_busy, irq;
    logic        serial_rom_present, serial_rom_valid;
    logic [7:0]  reg_addr;
    logic [1:0]  remote_which;
    logic [15:0] serial_rom_check;
    logic [31:0] reg_wdata, reg_rdata, remote_rdata;
    logic [31:0] res_reset [4];
    int          n_errors, samples_checked;

    csrsw_regs u_dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .remote_rd(remote_rd), .remote_which(remote_which),
        .remote_rdata(remote_rdata), .remote_valid(remote_valid), .serial_rom_present(serial_rom_present),
        .serial_rom_valid(serial_rom_valid), .serial_rom_check(serial_rom_check), .swap_busy(swap_busy), .irq(irq));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Gap off only where a read must follow at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic gap);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        if (gap) @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        chk(nm, reg_rdata, exp);
        @(posedge clock);
    endtask

    task automatic irq_is(input logic exp);
        @(negedge clock);
        chk("irq", {31'h0, irq}, {31'h0, exp});
        @(posedge clock);
    endtask

    // Host header read rides along so remote and host views can be compared
    task automatic remote(input logic [1:0] w, input logic [31:0] exp);
        remote_rd <= 1'b1;
        remote_which <= w;
        reg_addr <= 8'h18;
        reg_rd <= 1'b1;
        @(posedge clock);
        remote_rd <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge clock);
        chk("remote_rdata", remote_rdata, exp);
        chk("remote_valid", {31'h0, remote_valid}, 32'h1);
        @(posedge clock);
    endtask

    task automatic swap(input logic [1:0] sel, input logic [31:0] expv, input logic [31:0] newv);
        wr(8'h10, expv, 1'b1);
        wr(8'h0C, newv, 1'b1);
        wr(8'h14, {1'b1, 29'h1FFFFFFF, sel}, 1'b0);
        // Busy is only high in the cycle after the write, so sample it beside the read
        fork
            rd(8'h14, {30'h0, sel}, "control pending");
            begin
                @(negedge clock);
                chk("swap_busy", {31'h0, swap_busy}, 32'h1);
            end
        join
        rd(8'h14, {1'b1, 29'h0, sel}, "control done");
    endtask

    task automatic rom_pulse(input logic present);
        serial_rom_present <= present;
        serial_rom_check <= 16'hBEEF;
        serial_rom_valid <= 1'b1;
        @(posedge clock);
        serial_rom_valid <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        n_errors = 0;
        samples_checked = 0;
        {rstn, reg_wr, reg_rd, remote_rd, serial_rom_present, serial_rom_valid} = 6'h00;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        remote_which = 2'h0;
        serial_rom_check = 16'h0000;
        res_reset = '{32'h0000003F, 32'h00001333, 32'hFFFFFFFF, 32'hFFFFFFFF};
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        rd(8'h14, 32'h80000000, "control reset");
        rd(8'h18, 32'h00000000, "header reset");
        wr(8'h1C, 32'h00000000, 1'b1);
        rd(8'h1C, 32'h31333934, "bus name");
        rd(8'h30, 32'h00000000, "unmapped");
        for (int s = 0; s < 4; s++) rd(8'h50 + 8'(4 * s), res_reset[s], "resource reset");
        swap(2'h0, res_reset[0], 32'hA5A50000);
        irq_is(1'b0);
        wr(8'h44, 32'h00000003, 1'b1);
        irq_is(1'b1);
        wr(8'h40, 32'h00000003, 1'b1);
        irq_is(1'b0);
        for (int s = 1; s < 4; s++) swap(2'(s), res_reset[s], 32'h5A5A0000 | 32'(s));
        // Stale expected value must leave every resource alone
        for (int s = 0; s < 4; s++) begin
            swap(2'(s), 32'h0BAD0000, 32'h77777777);
            rd(8'h50 + 8'(4 * s), (s == 0) ? 32'hA5A50000 : (32'h5A5A0000 | 32'(s)), "resource");
        end
        wr(8'h40, 32'h00000003, 1'b1);
        wr(8'h18, 32'h12345678, 1'b1);
        rd(8'h18, 32'h12345678, "header rw");
        rom_pulse(1'b0);
        rd(8'h18, 32'h12345678, "header no rom");
        rom_pulse(1'b1);
        rd(8'h18, 32'h1234BEEF, "header from rom");
        irq_is(1'b1);
        remote(2'h0, 32'h1234BEEF);
        remote(2'h1, 32'h31333934);
        remote(2'h2, 32'h00000000);
        tally_and_finish();
    end
endmodule
